// file: hdl/tarc_pkg.sv
// Function
// - Scan reset clears the controller, no scan clock.
// - Scan reset low means normal, non-test operation.
// - Far end holds scan reset low when idle.
// - Mode select sampled on rising scan clock.
// - Data input captured on rising scan clock.
// - Data output updated on falling scan clock.
// - Far end holds mode select high when idle.
// - System reset low holds all logic reset; the user update register keeps its value.
// - Far end holds system reset low 200 us.
// - Clocks stable 200 us before system reset release.
// - Float input and scan reset low float outputs.
// - Far end holds float input high normally.
// - Far end ties factory inputs low.
package tarc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned MCLK_HZ = 10_000_000;
    localparam int unsigned SYS_RESET_MIN_US = 200;
    localparam int unsigned CLK_STABLE_MIN_US = 200;
    localparam int unsigned HOLD_MIN_US = (SYS_RESET_MIN_US > CLK_STABLE_MIN_US) ?
        SYS_RESET_MIN_US : CLK_STABLE_MIN_US;
    // Least time, rounded up to whole cycles
    localparam int unsigned HOLD_CYCLES = (HOLD_MIN_US * (MCLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] HOLD_COUNT = CNT_W'(HOLD_CYCLES);
    // Scan clock made by the host: 4 + 4 cycles gives 800 ns
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] SCAN_HALF_LAST = 4'h3;
    // Trailing low phase covers both synchronisers and the output update
    localparam logic [BIT_CNT_W-1:0] SCAN_TRAIL_LAST = 4'hb;

    // ************************************************************
    // Pin sampling
    // ************************************************************
    localparam int unsigned PIN_N = 6;
    localparam int unsigned PIN_CLK = 0;
    localparam int unsigned PIN_MODE = 1;
    localparam int unsigned PIN_DIN = 2;
    localparam int unsigned PIN_SRST = 3;
    localparam int unsigned PIN_FLOAT = 4;
    localparam int unsigned PIN_SYSRST = 5;
    // Idle levels: clock low, mode high, float off, both resets active
    localparam logic [PIN_N-1:0] PIN_RESET = 6'h12;

    // ************************************************************
    // Instructions and data registers
    // ************************************************************
    localparam int unsigned IR_W = 4;
    localparam int unsigned ID_W = 32;
    localparam int unsigned USER_W = 8;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] IR_USER = 4'h2;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    // Identification value is arbitrary; bit 0 set as the scan standard asks
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0a5a_0001;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tarc_tap_state_t;

    typedef enum {
        HOST_IDLE, HOST_SETUP, HOST_HIGH, HOST_TRAIL
    } tarc_host_state_t;

endpackage : tarc_pkg

// file: hdl/tarc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tarc_if;
    logic scan_clock;
    logic scan_mode_select;
    logic scan_data_in;
    logic scan_data_out;
    logic scan_data_out_oe;
    logic scan_reset_n;
    logic system_reset_n;
    logic float_outputs_n;
    logic factory_scan_enable;
    logic factory_scan_mode;
    logic memory_selftest_enable;
    logic factory_clock_disable;
    logic memory_selftest_done;
    logic memory_selftest_fail;
    logic scan_data_line;

    // No pull on the output: a released line reads inverted, so a lost enable shows
    assign scan_data_line = scan_data_out_oe ? scan_data_out : ~scan_data_out;

    modport device (
        input scan_clock, scan_mode_select, scan_data_in, scan_reset_n,
        input system_reset_n, float_outputs_n, factory_scan_enable,
        input factory_scan_mode, memory_selftest_enable, factory_clock_disable,
        output scan_data_out, scan_data_out_oe, memory_selftest_done,
        output memory_selftest_fail
    );

    modport host (
        output scan_clock, scan_mode_select, scan_data_in, scan_reset_n,
        output system_reset_n, float_outputs_n, factory_scan_enable,
        output factory_scan_mode, memory_selftest_enable, factory_clock_disable,
        input scan_data_out, scan_data_out_oe, memory_selftest_done,
        input memory_selftest_fail, scan_data_line
    );
endinterface : tarc_if
`default_nettype wire

// file: hdl/tarc_device.sv
`timescale 1ns/10ps
`default_nettype none
module tarc_device
    import tarc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    tarc_if.device link,
    input wire logic [USER_W-1:0] i_user_capture,
    output logic [USER_W-1:0] o_user_update,
    output logic o_user_update_pulse,
    output logic o_test_mode,
    output logic [IR_W-1:0] o_instruction,
    output logic o_core_reset,
    output logic o_outputs_float
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] sync1_reg;
    logic [PIN_N-1:0] sync2_reg;
    logic [PIN_N-1:0] sync3_reg;
    logic [PIN_N-1:0] filt_reg;
    logic [PIN_N-1:0] filt_next;

    // Gathered so one loop handles every pin alike
    assign pin_raw[PIN_CLK] = link.scan_clock;
    assign pin_raw[PIN_MODE] = link.scan_mode_select;
    assign pin_raw[PIN_DIN] = link.scan_data_in;
    assign pin_raw[PIN_SRST] = link.scan_reset_n;
    assign pin_raw[PIN_FLOAT] = link.float_outputs_n;
    assign pin_raw[PIN_SYSRST] = link.system_reset_n;

    genvar g;
    generate
        for (g = 0; g < PIN_N; g = g + 1) begin : g_pin
            // Accept a change only once stages two and three agree
            always_comb begin
                filt_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync2_reg[g] : filt_reg[g];
            end

            always_ff @(posedge i_mclk) begin
                if (!i_resetn) begin
                    sync1_reg[g] <= PIN_RESET[g];
                    sync2_reg[g] <= PIN_RESET[g];
                    sync3_reg[g] <= PIN_RESET[g];
                    filt_reg[g] <= PIN_RESET[g];
                end else if (i_ce) begin
                    sync1_reg[g] <= pin_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                    filt_reg[g] <= filt_next[g];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Controller
    // ************************************************************
    tarc_tap_state_t state_reg, state_next;
    logic clk_prev_reg, clk_prev_next;
    logic [IR_W-1:0] ir_reg, ir_next;
    logic [IR_W-1:0] ir_shift_reg, ir_shift_next;
    logic [ID_W-1:0] dr_shift_reg, dr_shift_next;
    logic [USER_W-1:0] user_reg, user_next;
    logic upd_pulse_reg, upd_pulse_next;
    logic tdo_reg, tdo_next;
    logic drive_reg, drive_next;
    logic oe_reg, oe_next;
    logic test_mode_reg, test_mode_next;
    logic core_reset_reg, core_reset_next;
    logic float_reg, float_next;
    logic scan_rise;
    logic scan_fall;
    logic tap_clear;

    // Edges of the sampled scan clock
    assign scan_rise = filt_reg[PIN_CLK] & ~clk_prev_reg;
    assign scan_fall = ~filt_reg[PIN_CLK] & clk_prev_reg;
    // Either reset clears the controller, scan clock or not
    assign tap_clear = ~filt_reg[PIN_SRST] | ~filt_reg[PIN_SYSRST];

    // Standard state walk on the sampled mode select
    function automatic tarc_tap_state_t tap_step(input tarc_tap_state_t s, input logic m);
        tarc_tap_state_t n;
        n = s;
        case (s)
            TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: n = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: n = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: n = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: n = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
            default: n = TAP_RESET;
        endcase
        return n;
    endfunction : tap_step

    // Next values: capture and shift on rise, output and update on fall
    always_comb begin
        state_next = state_reg;
        clk_prev_next = filt_reg[PIN_CLK];
        ir_next = ir_reg;
        ir_shift_next = ir_shift_reg;
        dr_shift_next = dr_shift_reg;
        user_next = user_reg;
        upd_pulse_next = 1'b0;
        tdo_next = tdo_reg;
        drive_next = drive_reg;
        test_mode_next = filt_reg[PIN_SRST];
        core_reset_next = ~filt_reg[PIN_SYSRST];
        float_next = ~filt_reg[PIN_FLOAT] & ~filt_reg[PIN_SRST];
        if (tap_clear) begin
            state_next = TAP_RESET;
            ir_next = IR_IDCODE;
            drive_next = 1'b0;
        end else if (scan_rise) begin
            state_next = tap_step(state_reg, filt_reg[PIN_MODE]);
            case (state_reg)
                TAP_RESET: begin
                    ir_next = IR_IDCODE;
                end
                TAP_CAP_IR: begin
                    ir_shift_next = IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    ir_shift_next = {filt_reg[PIN_DIN], ir_shift_reg[IR_W-1:1]};
                end
                TAP_CAP_DR: begin
                    case (ir_reg)
                        IR_IDCODE: dr_shift_next = ID_VALUE;
                        IR_USER: dr_shift_next = {{(ID_W-USER_W){1'b0}}, i_user_capture};
                        default: dr_shift_next = '0;
                    endcase
                end
                TAP_SHIFT_DR: begin
                    // Length of the shift path follows the instruction
                    case (ir_reg)
                        IR_IDCODE: begin
                            dr_shift_next = {filt_reg[PIN_DIN], dr_shift_reg[ID_W-1:1]};
                        end
                        IR_USER: begin
                            dr_shift_next = {{(ID_W-USER_W){1'b0}}, filt_reg[PIN_DIN],
                                dr_shift_reg[USER_W-1:1]};
                        end
                        default: begin
                            dr_shift_next = {{(ID_W-1){1'b0}}, filt_reg[PIN_DIN]};
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end else if (scan_fall) begin
            drive_next = (state_reg == TAP_SHIFT_IR) || (state_reg == TAP_SHIFT_DR);
            tdo_next = (state_reg == TAP_SHIFT_IR) ? ir_shift_reg[0] : dr_shift_reg[0];
            if (state_reg == TAP_UPD_IR) begin
                ir_next = ir_shift_reg;
            end
            if ((state_reg == TAP_UPD_DR) && (ir_reg == IR_USER)) begin
                user_next = dr_shift_reg[USER_W-1:0];
                upd_pulse_next = 1'b1;
            end
        end
        // Float wins over any shift phase
        oe_next = drive_next & ~float_next;
    end

    // Controller registers
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_reg <= TAP_RESET;
            clk_prev_reg <= 1'b0;
            ir_reg <= IR_IDCODE;
            ir_shift_reg <= '0;
            dr_shift_reg <= '0;
            user_reg <= '0;
            upd_pulse_reg <= 1'b0;
            tdo_reg <= 1'b0;
            drive_reg <= 1'b0;
            oe_reg <= 1'b0;
            test_mode_reg <= 1'b0;
            core_reset_reg <= 1'b1;
            float_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            clk_prev_reg <= clk_prev_next;
            ir_reg <= ir_next;
            ir_shift_reg <= ir_shift_next;
            dr_shift_reg <= dr_shift_next;
            user_reg <= user_next;
            upd_pulse_reg <= upd_pulse_next;
            tdo_reg <= tdo_next;
            drive_reg <= drive_next;
            oe_reg <= oe_next;
            test_mode_reg <= test_mode_next;
            core_reset_reg <= core_reset_next;
            float_reg <= float_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.scan_data_out = tdo_reg;
    assign link.scan_data_out_oe = oe_reg;
    // Factory self-test outputs carry nothing in this design
    assign link.memory_selftest_done = 1'b0;
    assign link.memory_selftest_fail = 1'b0;
    assign o_user_update = user_reg;
    assign o_user_update_pulse = upd_pulse_reg;
    assign o_test_mode = test_mode_reg;
    assign o_instruction = ir_reg;
    assign o_core_reset = core_reset_reg;
    assign o_outputs_float = float_reg;

endmodule : tarc_device
`default_nettype wire

// file: hdl/tarc_host.sv
`timescale 1ns/10ps
`default_nettype none
module tarc_host
    import tarc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    tarc_if.host link,
    input wire logic i_scan_enable,
    input wire logic i_system_reset_req,
    input wire logic i_clocks_stable,
    input wire logic i_float_req,
    input wire logic i_bit_valid,
    input wire logic i_bit_tms,
    input wire logic i_bit_tdi,
    output logic o_bit_ready,
    output logic o_bit_done,
    output logic o_bit_tdo,
    output logic o_system_released
);

    // ************************************************************
    // Returned data synchroniser
    // ************************************************************
    logic tdo_s1_reg, tdo_s2_reg, tdo_s3_reg, tdo_f_reg, tdo_f_next;

    // Accept a change only once stages two and three agree
    always_comb begin
        tdo_f_next = (tdo_s2_reg == tdo_s3_reg) ? tdo_s2_reg : tdo_f_reg;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            tdo_s1_reg <= 1'b0;
            tdo_s2_reg <= 1'b0;
            tdo_s3_reg <= 1'b0;
            tdo_f_reg <= 1'b0;
        end else if (i_ce) begin
            tdo_s1_reg <= link.scan_data_line;
            tdo_s2_reg <= tdo_s1_reg;
            tdo_s3_reg <= tdo_s2_reg;
            tdo_f_reg <= tdo_f_next;
        end
    end

    // ************************************************************
    // Bit sequencer and pin control
    // ************************************************************
    tarc_host_state_t state_reg, state_next;
    logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] hold_reg, hold_next;
    logic tck_reg, tck_next;
    logic tms_reg, tms_next;
    logic tdi_reg, tdi_next;
    logic srst_n_reg, srst_n_next;
    logic sysrst_n_reg, sysrst_n_next;
    logic float_n_reg, float_n_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;
    logic btdo_reg, btdo_next;

    // One bit: setup half, high half, long low trail, then sample
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 4'h1;
        tck_next = tck_reg;
        tms_next = tms_reg;
        tdi_next = tdi_reg;
        done_next = 1'b0;
        btdo_next = btdo_reg;
        hold_next = hold_reg;
        srst_n_next = i_scan_enable;
        float_n_next = ~i_float_req;
        case (state_reg)
            HOST_IDLE: begin
                cnt_next = '0;
                tms_next = 1'b1;
                if (i_bit_valid && srst_n_reg) begin
                    state_next = HOST_SETUP;
                    tms_next = i_bit_tms;
                    tdi_next = i_bit_tdi;
                end
            end
            HOST_SETUP: begin
                if (cnt_reg == SCAN_HALF_LAST) begin
                    state_next = HOST_HIGH;
                    tck_next = 1'b1;
                    cnt_next = '0;
                end
            end
            HOST_HIGH: begin
                if (cnt_reg == SCAN_HALF_LAST) begin
                    state_next = HOST_TRAIL;
                    tck_next = 1'b0;
                    cnt_next = '0;
                end
            end
            HOST_TRAIL: begin
                if (cnt_reg == SCAN_TRAIL_LAST) begin
                    state_next = HOST_IDLE;
                    cnt_next = '0;
                    done_next = 1'b1;
                    btdo_next = tdo_f_reg;
                end
            end
            default: begin
                state_next = HOST_IDLE;
                tck_next = 1'b0;
            end
        endcase
        // Hold time only runs on stable clocks with no request pending
        if (i_system_reset_req || !i_clocks_stable) begin
            hold_next = '0;
        end else if (hold_reg != HOLD_COUNT) begin
            hold_next = hold_reg + 12'h001;
        end
        sysrst_n_next = (hold_next == HOLD_COUNT);
        ready_next = (state_next == HOST_IDLE) && srst_n_next;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_reg <= HOST_IDLE;
            cnt_reg <= '0;
            hold_reg <= '0;
            tck_reg <= 1'b0;
            tms_reg <= 1'b1;
            tdi_reg <= 1'b0;
            srst_n_reg <= 1'b0;
            sysrst_n_reg <= 1'b0;
            float_n_reg <= 1'b1;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            btdo_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            hold_reg <= hold_next;
            tck_reg <= tck_next;
            tms_reg <= tms_next;
            tdi_reg <= tdi_next;
            srst_n_reg <= srst_n_next;
            sysrst_n_reg <= sysrst_n_next;
            float_n_reg <= float_n_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            btdo_reg <= btdo_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.scan_clock = tck_reg;
    assign link.scan_mode_select = tms_reg;
    assign link.scan_data_in = tdi_reg;
    assign link.scan_reset_n = srst_n_reg;
    assign link.system_reset_n = sysrst_n_reg;
    assign link.float_outputs_n = float_n_reg;
    // Factory inputs are always tied low
    assign link.factory_scan_enable = 1'b0;
    assign link.factory_scan_mode = 1'b0;
    assign link.memory_selftest_enable = 1'b0;
    assign link.factory_clock_disable = 1'b0;
    assign o_bit_ready = ready_reg;
    assign o_bit_done = done_reg;
    assign o_bit_tdo = btdo_reg;
    assign o_system_released = sysrst_n_reg;

endmodule : tarc_host
`default_nettype wire

// file: hdl/placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: test/tarc_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module tarc_asserts (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic scan_clock,
    input wire logic scan_mode_select,
    input wire logic scan_data_in,
    input wire logic scan_data_out,
    input wire logic scan_data_out_oe,
    input wire logic scan_reset_n,
    input wire logic system_reset_n,
    input wire logic float_outputs_n,
    input wire logic factory_scan_enable,
    input wire logic factory_scan_mode,
    input wire logic memory_selftest_enable,
    input wire logic factory_clock_disable,
    input wire logic memory_selftest_done,
    input wire logic memory_selftest_fail
);
    // ************************************************************
    // System reset low-time counter
    // ************************************************************
    logic [11:0] low_cnt_reg;
    logic [11:0] low_cnt_next;
    // Saturates, so a long hold never wraps under the limit
    always_comb begin
        low_cnt_next = system_reset_n ? 12'h000 : low_cnt_reg + {11'h000, ~&low_cnt_reg};
    end
    always_ff @(posedge i_mclk) begin
        low_cnt_next_q: low_cnt_reg <= i_resetn ? low_cnt_next : 12'h000;
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    factory_in_low_a: assert property (
        !(factory_scan_enable | factory_scan_mode | memory_selftest_enable | factory_clock_disable))
        else $error("factory input driven high");
    factory_out_low_a: assert property (
        !(memory_selftest_done | memory_selftest_fail)) else $error("factory output active");
    float_gate_a: assert property (
        (!float_outputs_n && !scan_reset_n)[*8] |-> !scan_data_out_oe)
        else $error("output still driven while floated");
    tdo_fall_a: assert property (
        $changed(scan_data_out) |-> !scan_clock && !$past(scan_clock, 2))
        else $error("data out moved away from falling clock");
    idle_mode_a: assert property (
        !scan_reset_n |-> scan_mode_select && !scan_clock) else $error("idle levels wrong");
    clock_high_a: assert property (
        $rose(scan_clock) |-> scan_clock[*4] ##[1:2] !scan_clock)
        else $error("scan clock high phase wrong");
    tdi_hold_a: assert property (
        $rose(scan_clock) |-> ($stable(scan_data_in) && $stable(scan_mode_select))[*4])
        else $error("data or mode moved while clock high");
    sys_hold_a: assert property (
        $rose(system_reset_n) |-> low_cnt_reg >= 12'h7d0) else $error("system reset too short");
endmodule : tarc_asserts
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tarc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic scan_en = 1'b0;
    logic sys_req = 1'b0;
    logic clk_ok = 1'b0;
    logic float_req = 1'b0;
    logic bit_valid = 1'b0;
    logic bit_tms = 1'b1;
    logic bit_tdi = 1'b0;
    logic [USER_W-1:0] user_cap = 8'h3c;
    logic [USER_W-1:0] user_upd;
    logic [IR_W-1:0] instr;
    logic upd_pulse, test_mode, core_rst, outs_float, bit_ready, bit_done, bit_tdo, sys_rel, t;
    logic [31:0] dout;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_upd = 0;
    tarc_if link_if();
    always #50 i_mclk = ~i_mclk;
    // Counts pulse cycles, so the width is checked too
    always @(posedge i_mclk) begin
        if (upd_pulse === 1'b1) n_upd++;
    end
    tarc_device i_tarc_device (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(1'b1),
        .link(link_if.device), .i_user_capture(user_cap), .o_user_update(user_upd),
        .o_user_update_pulse(upd_pulse), .o_test_mode(test_mode), .o_instruction(instr),
        .o_core_reset(core_rst), .o_outputs_float(outs_float));
    tarc_host i_tarc_host (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(1'b1),
        .link(link_if.host), .i_scan_enable(scan_en), .i_system_reset_req(sys_req),
        .i_clocks_stable(clk_ok), .i_float_req(float_req), .i_bit_valid(bit_valid),
        .i_bit_tms(bit_tms), .i_bit_tdi(bit_tdi), .o_bit_ready(bit_ready),
        .o_bit_done(bit_done), .o_bit_tdo(bit_tdo), .o_system_released(sys_rel));
    tarc_asserts i_tarc_asserts (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .scan_clock(link_if.scan_clock), .scan_mode_select(link_if.scan_mode_select),
        .scan_data_in(link_if.scan_data_in), .scan_data_out(link_if.scan_data_out),
        .scan_data_out_oe(link_if.scan_data_out_oe), .scan_reset_n(link_if.scan_reset_n),
        .system_reset_n(link_if.system_reset_n), .float_outputs_n(link_if.float_outputs_n),
        .factory_scan_enable(link_if.factory_scan_enable),
        .factory_scan_mode(link_if.factory_scan_mode),
        .memory_selftest_enable(link_if.memory_selftest_enable),
        .factory_clock_disable(link_if.factory_clock_disable),
        .memory_selftest_done(link_if.memory_selftest_done),
        .memory_selftest_fail(link_if.memory_selftest_fail));

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One scan bit through the host; bounded waits, the watchdog catches a hang
    task automatic xfer(input logic tms, input logic tdi, output logic tdo);
        int k;
        k = 0;
        while (bit_ready !== 1'b1 && k < 99) begin
            @(negedge i_mclk);
            k++;
        end
        chk(bit_ready, 1'b1);
        @(posedge i_mclk);
        bit_valid <= 1'b1;
        bit_tms <= tms;
        bit_tdi <= tdi;
        @(posedge i_mclk);
        bit_valid <= 1'b0;
        k = 0;
        do begin
            @(negedge i_mclk);
            k++;
        end while (bit_done !== 1'b1 && k < 99);
        chk(bit_done, 1'b1);
        tdo = bit_tdo;
    endtask : xfer

    // Idle to capture, n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        xfer(1'b1, 1'b0, t);
        if (ir) xfer(1'b1, 1'b0, t);
        xfer(1'b0, 1'b0, t);
        xfer(1'b0, 1'b0, dout[0]);
        for (int i = 0; i < n; i++) begin
            xfer(i == n - 1, din[i], t);
            if (i < n - 1) dout[i + 1] = t;
        end
        xfer(1'b1, 1'b0, t);
        xfer(1'b0, 1'b0, t);
    endtask : scan

    initial begin
        #2_000_000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (10) @(negedge i_mclk);
        chk(core_rst, 1'b1);
        chk(outs_float, 1'b0);
        @(posedge i_mclk);
        float_req <= 1'b1;
        clk_ok <= 1'b1;
        repeat (10) @(negedge i_mclk);
        chk(outs_float, 1'b1);
        chk(link_if.scan_data_out_oe, 1'b0);
        for (int k = 0; k < 2100 && sys_rel !== 1'b1; k++) @(negedge i_mclk);
        repeat (10) @(negedge i_mclk);
        chk(sys_rel, 1'b1);
        chk(core_rst, 1'b0);
        chk(test_mode, 1'b0);
        @(posedge i_mclk);
        scan_en <= 1'b1;
        repeat (10) @(negedge i_mclk);
        chk(test_mode, 1'b1);
        chk(outs_float, 1'b0);
        chk(instr, IR_IDCODE);
        for (int k = 0; k < 5; k++) xfer(1'b1, 1'b0, t);
        xfer(1'b0, 1'b0, t);
        scan(1'b0, ID_W, 32'h0);
        chk(dout, ID_VALUE);
        scan(1'b1, IR_W, {28'h0, IR_USER});
        chk(dout[IR_W-1:0], IR_CAPTURE);
        chk(instr, IR_USER);
        scan(1'b0, USER_W, 32'ha5);
        chk(dout[USER_W-1:0], 8'h3c);
        chk(user_upd, 8'ha5);
        chk(n_upd, 32'h1);
        // Five high mode bits reach reset from idle and restore identification
        for (int k = 0; k < 5; k++) xfer(1'b1, 1'b0, t);
        chk(instr, IR_IDCODE);
        xfer(1'b0, 1'b0, t);
        scan(1'b1, IR_W, {28'h0, IR_BYPASS});
        scan(1'b0, USER_W, 32'h81);
        chk(dout[USER_W-1:0], 8'h02);
        chk(n_upd, 32'h1);
        @(posedge i_mclk);
        scan_en <= 1'b0;
        repeat (10) @(negedge i_mclk);
        chk(test_mode, 1'b0);
        chk(instr, IR_IDCODE);
        chk(outs_float, 1'b1);
        @(posedge i_mclk);
        sys_req <= 1'b1;
        repeat (10) @(negedge i_mclk);
        chk(core_rst, 1'b1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
